// *** hdl/bia_defs.vh ***
// Constants for the 64-bit integer datapath
`ifndef BIA_DEFS_VH
`define BIA_DEFS_VH
`define BIA_XLEN        64
`define BIA_OPC_OPIMM   7'h13
`define BIA_OPC_OPIMM32 7'h1b
`define BIA_OPC_OP      7'h33
`define BIA_OPC_OP32    7'h3b
`define BIA_OPC_LUI     7'h37
`define BIA_OPC_AUIPC   7'h17
`define BIA_F3_ADD      3'h0
`define BIA_F3_SLL      3'h1
`define BIA_F3_SLT      3'h2
`define BIA_F3_SLTU     3'h3
`define BIA_F3_XOR      3'h4
`define BIA_F3_SR       3'h5
`define BIA_F3_OR       3'h6
`define BIA_F3_AND      3'h7
`define BIA_F7_BASE     7'h00
`define BIA_F7_ALT      7'h20
`define BIA_F6_BASE     6'h00
`define BIA_F6_ALT      6'h10
`define BIA_NREG_E      16
`define BIA_RST_RESULT  64'h0000000000000000
`endif

// *** hdl/bia_alu.v ***
// Registered integer datapath for the 64-bit base and embedded variant
`timescale 1ns/100ps
`default_nettype none
`include "bia_defs.vh"
module bia_alu (
   // Clock and reset
   input  wire        clk_in,
   input  wire        sys_rst_in,
   // Issue from decode
   input  wire        issue_valid_in,
   input  wire [31:0] instr_in,
   input  wire [63:0] pc_in,
   input  wire [63:0] rs1_val_in,
   input  wire [63:0] rs2_val_in,
   input  wire        embedded_in,
   // Result to register file
   output reg         wr_en_out,
   output reg  [4:0]  wr_addr_out,
   output reg  [63:0] wr_data_out,
   output reg         done_out,
   output reg         illegal_out
);

   // Sign-extend a word to full width
   function [63:0] sext32;
      input [31:0] v;
      begin
         sext32 = {{32{v[31]}}, v};
      end
   endfunction

   // Full or word shift: dir 0 left, 1 logical right, 2 arithmetic right
   function [63:0] shift64;
      input [63:0] v;
      input [5:0]  amt;
      input [1:0]  dir;
      begin
         case (dir)
            2'h0:    shift64 = v << amt;
            2'h1:    shift64 = v >> amt;
            default: shift64 = $signed(v) >>> amt;
         endcase
      end
   endfunction

   // Instruction fields
   wire [6:0]  opc   = instr_in[6:0];
   wire [4:0]  rd    = instr_in[11:7];
   wire [2:0]  f3    = instr_in[14:12];
   wire [4:0]  rs1   = instr_in[19:15];
   wire [4:0]  rs2   = instr_in[24:20];
   wire [6:0]  f7    = instr_in[31:25];
   wire [5:0]  f6    = instr_in[31:26];
   wire [63:0] imm_i = {{52{instr_in[31]}}, instr_in[31:20]};
   wire [63:0] imm_u = sext32({instr_in[31:12], 12'h000});

   // Operand values, with x0 forced to zero
   wire [63:0] a = (rs1 == 5'h00) ? 64'h0 : rs1_val_in;
   wire [63:0] b = (rs2 == 5'h00) ? 64'h0 : rs2_val_in;

   // Shift direction from bit 30 for right shifts
   wire [1:0]  sdir = (f3 == `BIA_F3_SLL) ? 2'h0 :
                      (instr_in[30] ? 2'h2 : 2'h1);
   // Word shift source, zero or sign extended for right shifts
   wire [63:0] wsrc = instr_in[30] ? sext32(a[31:0]) : {32'h0, a[31:0]};

   // Funct7 holds either the base or the alternate code
   function f7_pair;
      input [6:0] fn7;
      begin
         f7_pair = (fn7 == `BIA_F7_BASE) || (fn7 == `BIA_F7_ALT);
      end
   endfunction

   // Full-width immediate ops; shifts keep an opcode extension in imm[11:6]
   function legal_opimm;
      input [2:0] fn3;
      input [5:0] fn6;
      begin
         case (fn3)
            `BIA_F3_SLL: legal_opimm = (fn6 == `BIA_F6_BASE);
            `BIA_F3_SR:  legal_opimm = (fn6 == `BIA_F6_BASE) || (fn6 == `BIA_F6_ALT);
            default:     legal_opimm = 1'b1;
         endcase
      end
   endfunction

   // Word immediate ops: add and shifts, imm[5] must be clear
   function legal_opimm32;
      input [2:0] fn3;
      input [6:0] fn7;
      begin
         case (fn3)
            `BIA_F3_ADD: legal_opimm32 = 1'b1;
            `BIA_F3_SLL: legal_opimm32 = (fn7 == `BIA_F7_BASE);
            `BIA_F3_SR:  legal_opimm32 = f7_pair(fn7);
            default:     legal_opimm32 = 1'b0;
         endcase
      end
   endfunction

   // Full-width register ops: alternate code only for subtract and arithmetic shift
   function legal_op;
      input [2:0] fn3;
      input [6:0] fn7;
      begin
         case (fn3)
            `BIA_F3_ADD: legal_op = f7_pair(fn7);
            `BIA_F3_SR:  legal_op = f7_pair(fn7);
            default:     legal_op = (fn7 == `BIA_F7_BASE);
         endcase
      end
   endfunction

   // Word register ops: add, subtract and the three shifts
   function legal_op32;
      input [2:0] fn3;
      input [6:0] fn7;
      begin
         case (fn3)
            `BIA_F3_ADD: legal_op32 = f7_pair(fn7);
            `BIA_F3_SLL: legal_op32 = (fn7 == `BIA_F7_BASE);
            `BIA_F3_SR:  legal_op32 = f7_pair(fn7);
            default:     legal_op32 = 1'b0;
         endcase
      end
   endfunction

   // Opcode classes
   wire is_opimm   = (opc == `BIA_OPC_OPIMM);
   wire is_opimm32 = (opc == `BIA_OPC_OPIMM32);
   wire is_op      = (opc == `BIA_OPC_OP);
   wire is_op32    = (opc == `BIA_OPC_OP32);

   // Source fields read by the encoding; upper immediates read none
   wire uses_rs1 = is_opimm || is_opimm32 || is_op || is_op32;
   wire uses_rs2 = is_op || is_op32;

   // Full-width shifts, amount from the low six bits
   wire [63:0] sh_imm = shift64(a, instr_in[25:20], sdir);
   wire [63:0] sh_reg = shift64(a, b[5:0], sdir);

   // Word shifts, low word kept before sign extension
   wire [63:0] wsh_imm_full = shift64(wsrc, {1'b0, instr_in[24:20]}, sdir);
   wire [63:0] wsh_reg_full = shift64(wsrc, {1'b0, b[4:0]}, sdir);
   wire [31:0] wsh_imm      = wsh_imm_full[31:0];
   wire [31:0] wsh_reg      = wsh_reg_full[31:0];

   // Word add and subtract; overflow leaves with the upper half
   wire [31:0] wadd_imm = a[31:0] + imm_i[31:0];
   wire [31:0] wadd_reg = instr_in[30] ? a[31:0] - b[31:0] : a[31:0] + b[31:0];

   // Combinational decode results
   reg [63:0] res;
   reg [31:0] wres;
   reg        legal;

   // Encoding legality, before the register limit of the embedded variant
   always @* begin
      legal = 1'b0;
      case (opc)
         // Each class has its own extension check
         `BIA_OPC_OPIMM:   legal = legal_opimm(f3, f6);
         `BIA_OPC_OPIMM32: legal = legal_opimm32(f3, f7);
         `BIA_OPC_OP:      legal = legal_op(f3, f7);
         `BIA_OPC_OP32:    legal = legal_op32(f3, f7);
         // Upper immediates have no further fields to check
         `BIA_OPC_LUI:     legal = 1'b1;
         `BIA_OPC_AUIPC:   legal = 1'b1;
         default:          legal = 1'b0;
      endcase
   end

   // Low word of the word-sized operations
   always @* begin
      wres = 32'h0;
      case (opc)
         // Immediate word ops
         `BIA_OPC_OPIMM32: begin
            if (f3 == `BIA_F3_ADD) begin
               wres = wadd_imm;
            end else begin
               wres = wsh_imm;
            end
         end
         // Register word ops
         `BIA_OPC_OP32: begin
            if (f3 == `BIA_F3_ADD) begin
               wres = wadd_reg;
            end else begin
               wres = wsh_reg;
            end
         end
         default: wres = 32'h0;
      endcase
   end

   // Result at full width; word results sign-extended from bit 31
   always @* begin
      res = 64'h0;
      case (opc)
         `BIA_OPC_OPIMM: begin
            case (f3)
               `BIA_F3_ADD:  res = a + imm_i;
               // Comparisons give one or zero in bit 0
               `BIA_F3_SLT:  res = {63'h0, $signed(a) < $signed(imm_i)};
               `BIA_F3_SLTU: res = {63'h0, a < imm_i};
               // Bitwise logic against the immediate
               `BIA_F3_XOR:  res = a ^ imm_i;
               `BIA_F3_OR:   res = a | imm_i;
               `BIA_F3_AND:  res = a & imm_i;
               default:      res = sh_imm;
            endcase
         end

         `BIA_OPC_OP: begin
            case (f3)
               `BIA_F3_ADD:  res = instr_in[30] ? a - b : a + b;
               // Comparisons give one or zero in bit 0
               `BIA_F3_SLT:  res = {63'h0, $signed(a) < $signed(b)};
               `BIA_F3_SLTU: res = {63'h0, a < b};
               // Bitwise logic between the two sources
               `BIA_F3_XOR:  res = a ^ b;
               `BIA_F3_OR:   res = a | b;
               `BIA_F3_AND:  res = a & b;
               default:      res = sh_reg;
            endcase
         end

         `BIA_OPC_OPIMM32: res = sext32(wres);
         `BIA_OPC_OP32:    res = sext32(wres);
         `BIA_OPC_LUI:     res = imm_u;
         `BIA_OPC_AUIPC:   res = pc_in + imm_u;
         default:          res = 64'h0;
      endcase
   end

   // Embedded variant: any named register above 15 is reserved
   // rd is checked even where the write would be dropped
   wire rd_hi  = rd[4];
   wire rs1_hi = uses_rs1 && rs1[4];
   wire rs2_hi = uses_rs2 && rs2[4];
   wire e_bad  = embedded_in && (rd_hi || rs1_hi || rs2_hi);

   // Reserved or unsupported encodings never write back
   wire ok = legal && !e_bad;

   // Completion pulse one cycle after each issue
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         done_out    <= 1'b0;
         illegal_out <= 1'b0;
      end else begin
         // Every issue completes; nothing stalls
         done_out    <= issue_valid_in;
         illegal_out <= issue_valid_in && !ok;
      end
   end

   // Write strobe; x0 writes are dropped as hints, not flagged
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_en_out <= 1'b0;
      end else begin
         // Illegal encodings leave the destination unchanged
         wr_en_out <= issue_valid_in && ok && (rd != 5'h00);
      end
   end

   // Destination and result, held for one cycle
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_addr_out <= 5'h00;
         wr_data_out <= `BIA_RST_RESULT;
      end else begin
         // Data follows every cycle; meaningful with done
         wr_addr_out <= rd;
         wr_data_out <= res;
      end
   end

endmodule
`default_nettype wire

// *** verification/bia_alu_props.sv ***
// Port checks for the integer datapath
`timescale 1ns/100ps
`default_nettype none
module bia_alu_props (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        issue_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic [63:0] pc_in,
   input wire logic [63:0] rs1_val_in,
   input wire logic        embedded_in,
   input wire logic        wr_en_out,
   input wire logic [4:0]  wr_addr_out,
   input wire logic [63:0] wr_data_out,
   input wire logic        done_out,
   input wire logic        illegal_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Full-register issue of one opcode with a live target
   sequence s_iss(op);
      issue_valid_in && instr_in[6:0] == op && !embedded_in && instr_in[11:7] != 5'h00;
   endsequence
   AST_DONE: assert property (issue_valid_in |=> done_out) else $error("done missing");
   AST_IDLE: assert property (!issue_valid_in |=> !done_out) else $error("stray done");
   AST_X0: assert property (issue_valid_in && instr_in[11:7] == 5'h00 |=> !wr_en_out)
      else $error("write to zero register");
   AST_XORI: assert property (s_iss(7'h13) ##0 instr_in[14:12] == 3'h4 |=> wr_en_out &&
      wr_data_out == $past((instr_in[19:15] == 5'h00 ? 64'h0 : rs1_val_in) ^
                           {{52{instr_in[31]}}, instr_in[31:20]}))
      else $error("xor immediate result wrong");
   AST_ADDIW: assert property (s_iss(7'h1b) ##0 instr_in[14:12] == 3'h0 |=> wr_en_out &&
      wr_data_out[31:0] == $past((instr_in[19:15] == 5'h00 ? 32'h0 : rs1_val_in[31:0]) +
                                 {{20{instr_in[31]}}, instr_in[31:20]})
      && wr_data_out[63:32] == {32{wr_data_out[31]}}) else $error("word add immediate wrong");
   AST_LUI: assert property (s_iss(7'h37) |=> wr_data_out ==
      {{32{$past(instr_in[31])}}, $past(instr_in[31:12]), 12'h000}) else $error("upper load wrong");
   AST_AUIPC: assert property (s_iss(7'h17) |=> wr_data_out ==
      $past(pc_in + {{32{instr_in[31]}}, instr_in[31:12], 12'h000})) else $error("pc add wrong");
   AST_RSVW: assert property (s_iss(7'h1b) ##0 instr_in[13:12] == 2'b01 && instr_in[25]
      |=> illegal_out && !wr_en_out) else $error("reserved word shift accepted");
   AST_EMB: assert property (issue_valid_in && embedded_in && instr_in[11]
      |=> illegal_out && !wr_en_out) else $error("high register accepted");
   AST_ILL: assert property (illegal_out |-> done_out && !wr_en_out)
      else $error("illegal with write");
endmodule
bind bia_alu bia_alu_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .issue_valid_in(issue_valid_in), .instr_in(instr_in), .pc_in(pc_in),
   .rs1_val_in(rs1_val_in), .embedded_in(embedded_in), .wr_en_out(wr_en_out),
   .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .done_out(done_out),
   .illegal_out(illegal_out));
`default_nettype wire

// *** verification/bia_rf_model.sv ***
// Register file model feeding operands to the datapath
`timescale 1ns/100ps
`default_nettype none
module bia_rf_model (
   // Clock and read selects
   input  wire logic        clk_in,
   input  wire logic [31:0] instr_in,
   // Write back
   input  wire logic        wr_en_in,
   input  wire logic [4:0]  wr_addr_in,
   input  wire logic [63:0] wr_data_in,
   // Operands
   output logic      [63:0] rs1_val_out,
   output logic      [63:0] rs2_val_out
);
   logic [63:0] regs_q [32];
   // Seed pattern, x0 nonzero to stress zero forcing
   initial for (int n = 0; n < 32; n++) regs_q[n] = 64'h9e3779b97f4a7c15 * (n + 1);
   // Write back on result pulse
   always @(posedge clk_in) if (wr_en_in) regs_q[wr_addr_in] <= wr_data_in;
   assign rs1_val_out = regs_q[instr_in[19:15]];
   assign rs2_val_out = regs_q[instr_in[24:20]];
endmodule
`default_nettype wire

// *** verification/bia_alu_tb.sv ***
// Random self-checking bench for the integer datapath
`timescale 1ns/100ps
`default_nettype none
module bia_alu_tb;
   logic        clk_in = 0, sys_rst_in = 1, issue_valid_in = 0, embedded_in = 0;
   logic        wr_en_out, done_out, illegal_out, ev = 0, ee = 0, ei = 0;
   logic [4:0]  wr_addr_out, ea;
   logic [31:0] instr_in = 0;
   logic [63:0] pc_in = 0, rs1_val_in, rs2_val_in, wr_data_out, ed;
   logic [71:0] got, exp;
   int          n_fail = 0, checked = 0, k, t;
   logic [31:0] tpl [31] = '{32'h00004013, 32'h0000001b, 32'h00001013, 32'h00005013,
      32'h40005013, 32'h0000101b, 32'h0000501b, 32'h4000501b, 32'h00000037, 32'h00000017,
      32'h0000003b, 32'h4000003b, 32'h00001033, 32'h00005033, 32'h40005033, 32'h0000103b,
      32'h0000503b, 32'h4000503b, 32'h00004033, 32'h00000013, 32'h00002013, 32'h00003013,
      32'h00006013, 32'h00007013, 32'h00000033, 32'h40000033, 32'h00002033, 32'h00003033,
      32'h00006033, 32'h00007033, 32'h00000003};
   bia_alu u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .issue_valid_in(issue_valid_in),
      .instr_in(instr_in), .pc_in(pc_in), .rs1_val_in(rs1_val_in), .rs2_val_in(rs2_val_in),
      .embedded_in(embedded_in), .wr_en_out(wr_en_out), .wr_addr_out(wr_addr_out),
      .wr_data_out(wr_data_out), .done_out(done_out), .illegal_out(illegal_out));
   bia_rf_model u_rf (.clk_in(clk_in), .instr_in(instr_in), .wr_en_in(wr_en_out),
      .wr_addr_in(wr_addr_out), .wr_data_in(wr_data_out), .rs1_val_out(rs1_val_in),
      .rs2_val_out(rs2_val_in));
   // Reference result: {illegal, write, data}
   function automatic logic [65:0] model(logic [31:0] i, logic [63:0] p, a, b, logic e);
      logic [63:0] im, o, r;
      logic [5:0]  sh;
      logic        w, rr, il;
      w = i[3];
      rr = i[5];
      im = {{52{i[31]}}, i[31:20]};
      if (i[19:15] == 5'h00) a = 0;
      if (i[24:20] == 5'h00) b = 0;
      o = rr ? b : im;
      if (w) a = i[30] ? {{32{a[31]}}, a[31:0]} : {32'h0, a[31:0]};
      sh = w ? {1'b0, o[4:0]} : o[5:0];
      case (i[14:12])
         3'h0: r = (rr && i[30]) ? a - o : a + o;
         3'h1: r = a << sh;
         3'h4: r = a ^ o;
         3'h2: r = {63'h0, $signed(a) < $signed(o)};
         3'h3: r = {63'h0, a < o};
         3'h6: r = a | o;
         3'h7: r = a & o;
         default: if (i[30]) r = $signed(a) >>> sh; else r = a >> sh;
      endcase
      if (w) r = {{32{r[31]}}, r[31:0]};
      if (i[6:0] == 7'h37) r = {{32{i[31]}}, i[31:12], 12'h000};
      if (i[6:0] == 7'h17) r = p + {{32{i[31]}}, i[31:12], 12'h000};
      il = (i[6:0] == 7'h03) || (!rr && w && i[12] && i[25]) ||
           (e && (i[11] || (!i[2] && (i[19] || (rr && i[24])))));
      return {il, !il && i[11:7] != 5'h00, r};
   endfunction
   task automatic wrap_up;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Clock
   initial forever #10 clk_in = ~clk_in;
   // Watchdog
   initial begin
      #(20 * 4000);
      n_fail++;
      wrap_up();
   end
   // Random issue stream, every result compared next cycle
   initial begin
      void'($urandom(32'h949784c4));
      ev = 0;
      repeat (2) @(posedge clk_in);
      #1 sys_rst_in = 0;
      for (k = 0; k < 3000; k++) begin
         @(posedge clk_in);
         #1 got = {done_out, wr_en_out, illegal_out, ee ? {wr_addr_out, wr_data_out} : 69'h0};
         exp = {ev, ee, ei, ee ? {ea, ed} : 69'h0};
         checked++;
         if (got !== exp) begin
            n_fail++;
            $display("ERROR result expected %h seen %h", exp, got);
         end
         t = $urandom % 31;
         instr_in = tpl[t] | ($urandom & (t < 2 ? 32'hffff8f80 : t < 8 ? 32'h03ff8f80 :
            t < 10 ? 32'hffffff80 : t < 19 ? 32'h01ff8f80 : t < 24 ? 32'hffff8f80 :
            t < 30 ? 32'h01ff8f80 : 32'hffffff80));
         issue_valid_in = $urandom % 5 != 0;
         embedded_in = $urandom % 4 == 0;
         pc_in = {$urandom, $urandom};
         #1 {ei, ee, ed} = model(instr_in, pc_in, rs1_val_in, rs2_val_in, embedded_in);
         ev = issue_valid_in;
         ee = ee && ev;
         ei = ei && ev;
         ea = instr_in[11:7];
      end
      wrap_up();
   end
endmodule
`default_nettype wire
